// file: dv/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
    input logic clk_i,
    input logic nrst_i,
    input logic reset_i,
    input logic stack_start_i,
    input logic clear_imask_i,
    input logic cli_i,
    output logic imask_o
);
    // interrupt mask bit: set by reset and interrupt entry, cleared by software or low power
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            imask_o <= 1'b1;
        else if (reset_i || stack_start_i)
            imask_o <= 1'b1;
        else if (clear_imask_i || cli_i)
            imask_o <= 1'b0;
    end
endmodule // cpu_core_model

// file: dv/sysint_checker_asserts.sv
`timescale 1ns/1ps
`include "sysint_consts.vh"
module sysint_checker #(
    parameter LONG_CYCLES = 4096,
    parameter SHORT_CYCLES = 32
) (
    input logic clk_i,
    input logic nrst_i,
    input logic [19:0] irq_req_i,
    input logic swi_exec_i,
    input logic break_i,
    input logic wait_exec_i,
    input logic stop_exec_i,
    input logic cpu_imask_i,
    input logic por_i,
    input logic watchdog_rst_i,
    input logic bad_instruction_i,
    input logic unmapped_access_i,
    input logic opcode_fetch_i,
    input logic undervoltage_i,
    input logic monitor_entry_i,
    input logic watchdog_disable_i,
    input logic internal_reset_o,
    input logic [4:0] vector_code_o,
    input logic irq_pending_o,
    input logic clear_imask_o,
    input logic cpu_clk_en_o,
    input logic periph_clk_en_o,
    input logic osc_clk_en_o,
    input logic watchdog_run_o,
    input logic flag_clear_allow_o,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // core running and leaving for a low power state
    sequence s_lp_entry;
        (wait_exec_i || stop_exec_i) && cpu_clk_en_o && !internal_reset_o;
    endsequence
    // pin reset is left out: its synchroniser adds latency
    sequence s_any_reset;
        por_i || watchdog_rst_i || bad_instruction_i || undervoltage_i || monitor_entry_i
            || (unmapped_access_i && opcode_fetch_i);
    endsequence
    a_reset_wins: assert property (s_any_reset |=> internal_reset_o)
        else $error("internal reset missing after a reset source");
    a_swi_break_top: assert property ((swi_exec_i || break_i) |=> vector_code_o == 5'h01)
        else $error("software or break vector not chosen");
    a_line_one_prio: assert property (irq_req_i[0] && !cpu_imask_i && !swi_exec_i
        && !break_i && !internal_reset_o |=> vector_code_o == 5'h02)
        else $error("first request line not chosen");
    a_idle_no_pending: assert property (!(|irq_req_i) && !swi_exec_i && !break_i
        |=> !irq_pending_o)
        else $error("pending flag set with no request");
    a_imask_clear: assert property (s_lp_entry |=> clear_imask_o)
        else $error("mask clear missing after low power entry");
    a_wait_gating: assert property (wait_exec_i && cpu_clk_en_o && !internal_reset_o
        |-> ##[1:2] (!cpu_clk_en_o && periph_clk_en_o))
        else $error("wait clock gating wrong");
    a_stop_gating: assert property (stop_exec_i && cpu_clk_en_o && !internal_reset_o
        |-> ##[1:2] !(cpu_clk_en_o || periph_clk_en_o || osc_clk_en_o))
        else $error("stop clock gating wrong");
    a_watchdog_on: assert property (!watchdog_disable_i |=> watchdog_run_o)
        else $error("watchdog not running while enabled");
    a_clear_outside: assert property (!break_i |=> flag_clear_allow_o)
        else $error("flag clearing blocked outside break");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule // sysint_checker
bind system_integration_unit sysint_checker #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
) sysint_checker_inst (.*);

// file: dv/system_integration_unit_tb.sv
`timescale 1ns/1ps
`include "sysint_consts.vh"
module system_integration_unit_tb;
    localparam int LONG_N = 64;
    localparam int SHORT_N = 8;
    logic clk_i = 1'b0, nrst_i = 1'b0, cli = 1'b0;
    logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0, irq_req_i = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
    logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_rvalid, swi_exec_i = 0, break_i = 0, wait_exec_i = 0, stop_exec_i = 0;
    logic [6:0] rsrc = '0;
    logic por_i, rst_pin_n_i, watchdog_rst_i, bad_instruction_i, unmapped_access_i;
    logic undervoltage_i, monitor_entry_i, cpu_imask_i, opcode_fetch_i = 0;
    logic short_stop_recovery_i = 0, watchdog_disable_i = 0;
    logic internal_reset_o, irq_pending_o, stack_start_o, clear_imask_o, cpu_clk_en_o;
    logic periph_clk_en_o, osc_clk_en_o, watchdog_run_o, flag_clear_allow_o, in_break_o;
    logic [4:0] vector_code_o;
    int n_mismatch = 0, n_compared = 0;
    // reset sources by index: por, pin, watchdog, opcode, fetch, undervoltage, monitor
    assign {monitor_entry_i, undervoltage_i, unmapped_access_i} = rsrc[6:4];
    assign {bad_instruction_i, watchdog_rst_i, por_i} = {rsrc[3:2], rsrc[0]};
    assign rst_pin_n_i = ~rsrc[1];
    always #10 clk_i = ~clk_i;
    system_integration_unit #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N))
        system_integration_unit_inst (.*);
    cpu_core_model cpu_core_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .reset_i(internal_reset_o), .stack_start_i(stack_start_o),
        .clear_imask_i(clear_imask_o), .cli_i(cli), .imask_o(cpu_imask_i));
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", 32'(s_axi_bresp), 32'(`RESP_OKAY));
    endtask
    task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rd_chk(input string nm, input logic [19:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, {24'h0, e});
    endtask
    task automatic pulse(input int k, input logic f);
        opcode_fetch_i <= f;
        rsrc[k] <= 1'b1;
        step(8);
        rsrc[k] <= 1'b0;
        opcode_fetch_i <= 1'b0;
        step(8);
    endtask
    task automatic t_cause();
        int src[5] = '{4, 4, 3, 6, 1};
        logic [7:0] exp[5] = '{8'h00, 8'h08, 8'h10, 8'h04, 8'h40};
        rd_chk("cause_por", 20'h3f804, 8'h80);
        rd_chk("cause_cleared", 20'h3f804, 8'h00);
        pulse(2, 1'b0);
        pulse(5, 1'b0);
        rd_chk("cause_stacked", 20'h3f804, 8'h22);
        foreach (src[i]) begin
            pulse(src[i], i == 1);
            rd_chk("cause_each", 20'h3f804, exp[i]);
        end
        pulse(2, 1'b0);
        pulse(0, 1'b0);
        rd_chk("cause_por_wipes", 20'h3f804, 8'h80);
        $display("done cause");
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        wr(20'h3f80c, 8'h80);
        rd_chk("ctrl_set", 20'h3f80c, 8'h80);
        wr(20'h3f80c, 8'h00);
        rd_chk("ctrl_clr", 20'h3f80c, 8'h00);
        rd(20'h3f808, d, r);
        chk("unmapped", 32'(r), 32'(`RESP_DECERR));
        $display("done regs");
    endtask
    task automatic t_pend();
        logic [19:0] p[3] = '{20'hfffff, 20'ha5a5a, 20'h00000};
        foreach (p[i]) begin
            irq_req_i <= p[i];
            step(2);
            rd_chk("pend_a", 20'h3f840, {p[i][5:0], 2'b00});
            rd_chk("pend_b", 20'h3f844, p[i][13:6]);
            rd_chk("pend_c", 20'h3f848, {2'b00, p[i][19:14]});
        end
        wr(20'h3f840, 8'hff);
        rd_chk("pend_wr", 20'h3f840, 8'h00);
        $display("done pending");
    endtask
    task automatic t_prio();
        cli <= 1'b1;
        step(1);
        cli <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            irq_req_i <= 20'h0ffff & ~((20'h1 << k) - 20'h1);
            step(2);
            chk("vector", 32'(vector_code_o), 32'(k + 2));
        end
        swi_exec_i <= 1'b1;
        step(2);
        chk("vector_swi", 32'(vector_code_o), 32'(`VEC_SWI));
        swi_exec_i <= 1'b0;
        irq_req_i <= '0;
        step(2);
        chk("no_pending", 32'(irq_pending_o), 32'h0);
        $display("done priority");
    endtask
    task automatic enter(input logic stop);
        wait_exec_i <= ~stop;
        stop_exec_i <= stop;
        step(1);
        wait_exec_i <= 1'b0;
        stop_exec_i <= 1'b0;
        step(4);
    endtask
    task automatic wake(output int n);
        irq_req_i <= 20'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!stack_start_o);
        irq_req_i <= '0;
        step(3);
    endtask
    task automatic t_wait();
        int n;
        enter(1'b0);
        chk("wait_clks", {cpu_clk_en_o, periph_clk_en_o}, 32'h1);
        chk("wait_mask", 32'(cpu_imask_i), 32'h0);
        chk("wait_wdog", 32'(watchdog_run_o), 32'h1);
        wake(n);
        chk("wake_delay", n, 2);
        chk("woken_cpu", 32'(cpu_clk_en_o), 32'h1);
        watchdog_disable_i <= 1'b1;
        step(2);
        chk("wdog_off", 32'(watchdog_run_o), 32'h0);
        watchdog_disable_i <= 1'b0;
        $display("done wait");
    endtask
    task automatic t_break();
        enter(1'b0);
        break_i <= 1'b1;
        step(4);
        chk("break_vec", 32'(vector_code_o), 32'(`VEC_SWI));
        chk("protect", 32'(flag_clear_allow_o), 32'h0);
        chk("in_break", 32'(in_break_o), 32'h1);
        rd_chk("exit_flag", 20'h3f800, 8'h02);
        wr(20'h3f80c, 8'h80);
        step(2);
        chk("allow", 32'(flag_clear_allow_o), 32'h1);
        wr(20'h3f800, 8'h00);
        rd_chk("exit_clr", 20'h3f800, 8'h00);
        break_i <= 1'b0;
        wr(20'h3f80c, 8'h00);
        step(2);
        chk("allow_after", 32'(flag_clear_allow_o), 32'h1);
        $display("done break");
    endtask
    task automatic t_stop();
        int n;
        for (int s = 0; s < 2; s++) begin
            short_stop_recovery_i <= s[0];
            enter(1'b1);
            chk("stop_clks", {cpu_clk_en_o, periph_clk_en_o, osc_clk_en_o}, 0);
            wake(n);
            chk("recovery", 32'(n >= (s ? SHORT_N : LONG_N) && n <= (s ? SHORT_N : LONG_N) + 4),
                32'h1);
        end
        enter(1'b1);
        pulse(2, 1'b0);
        chk("stop_reset", 32'(cpu_clk_en_o), 32'h1);
        $display("done stop");
    endtask
    // watchdog on the whole run
    initial begin
        #(20 * 20000);
        n_mismatch++;
        close_out();
    end
    initial begin
        step(3);
        nrst_i <= 1'b1;
        step(1);
        t_cause();
        t_regs();
        t_pend();
        t_prio();
        t_wait();
        t_break();
        t_stop();
        close_out();
    end
endmodule // system_integration_unit_tb

// file: hdl/recovery_timer.v
`timescale 1ns/1ps
`include "sysint_consts.vh"
// times the stop recovery period on the oscillator clock
module recovery_timer #(
    parameter LONG_CYCLES = `RECOVER_LONG,
    parameter SHORT_CYCLES = `RECOVER_SHORT
) (
    input wire clk_i,
    input wire nrst_i,
    input wire hold_clear_i,
    input wire start_i,
    input wire short_i,
    output reg done_o
);
    localparam [12:0] LONG_END = LONG_CYCLES[12:0] - 13'h0001;
    localparam [12:0] SHORT_END = SHORT_CYCLES[12:0] - 13'h0001;
    reg [12:0] cnt_ff;
    reg run_ff;
    reg [12:0] end_ff;

    // counter held at zero during stop, then counts the selected length
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= 13'h0000;
            run_ff <= 1'b0;
            end_ff <= 13'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (hold_clear_i) begin
                cnt_ff <= 13'h0000;
                run_ff <= 1'b0;
            end else if (start_i) begin
                cnt_ff <= 13'h0000;
                run_ff <= 1'b1;
                end_ff <= short_i ? SHORT_END : LONG_END;
            end else if (run_ff) begin
                if (cnt_ff == end_ff) begin
                    run_ff <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 13'h0001;
                end
            end
        end
    end
endmodule // recovery_timer

// file: hdl/sysint_consts.vh
`ifndef SYSINT_CONSTS_VH
`define SYSINT_CONSTS_VH
// register indices; byte address is four times the index
`define IDX_BREAK_STATUS 18'h0fe00
`define IDX_RESET_CAUSE 18'h0fe01
`define IDX_BREAK_CTRL 18'h0fe03
`define IDX_PEND_A 18'h0fe10
`define IDX_PEND_B 18'h0fe11
`define IDX_PEND_C 18'h0fe12
`define ADDR_W 20
// reset cause bit positions
`define RC_POR 7
`define RC_PIN 6
`define RC_WDOG 5
`define RC_BADOP 4
`define RC_BADFETCH 3
`define RC_MONITOR 2
`define RC_UNDERV 1
// other field positions
`define BWS_EXIT_BIT 1
`define BFC_ENABLE_BIT 7
`define BYTE_ZERO 8'h00
`define RC_RESET 8'h80
// number of maskable request lines
`define NUM_REQ 20
// vector codes: 0 none, 1 software interrupt, 2.. request line index + 2
`define VEC_NONE 5'h00
`define VEC_SWI 5'h01
`define VEC_BASE 5'h02
// low power states
`define ST_RUN 2'h0
`define ST_WAIT 2'h1
`define ST_STOP 2'h2
`define ST_RECOVER 2'h3
// recovery lengths in oscillator cycles
`define RECOVER_LONG 4096
`define RECOVER_SHORT 32
// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// file: hdl/system_integration_unit.v
// What this block does
// - pending flags show 1 while each source requests, 0 otherwise.
// - fixed priority: software interrupt first, then lines one to twenty.
// - bits 1 and 0 of pending register a read zero.
// - bits 7 and 6 of pending register c read zero.
// - every reset source but the pin (synchronised first) acts at once, above interrupts, unarbitrated.
// - a break forces the cpu onto the software interrupt vector.
// - in break with clear enable off, flag clearing elsewhere is blocked.
// - a flag cleared in break with clearing enabled stays cleared.
// - two-step clears stay blocked in break; second step works after.
// - wait or stop clears the cpu interrupt mask.
// - wait stops cpu clocks, peripherals run, interrupts wake the cpu.
// - interrupt stacking starts one cycle after the wake cycle.
// - wait ends on reset or break; break sets the exited-wait flag.
// - watchdog runs, also in wait, when its disable bit is zero.
// - stop resets the counter, gates cpu, peripheral and oscillator clocks; interrupt or reset ends it.
// - stop recovery lasts 4096 cycles, or 32 when short recovery set.
// - counter held clear during stop, then times the recovery.
// - six registers decoded at their fixed addresses, user accessible.
// - reading the reset cause register returns flags then clears them.
// - power-on sets its flag and clears others; others only set theirs.
// - separate flags for pin, watchdog, opcode, fetch, voltage, monitor.
// - break clear enable is read/write; 1 allows clearing in break.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sysint_consts.vh"
module system_integration_unit #(
    parameter LONG_CYCLES = `RECOVER_LONG,
    parameter SHORT_CYCLES = `RECOVER_SHORT
) (
    input wire clk_i,
    input wire nrst_i,
    // axi4-lite slave
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // interrupt requests and cpu handshake
    input wire [`NUM_REQ-1:0] irq_req_i,
    input wire swi_exec_i,
    input wire break_i,
    input wire wait_exec_i,
    input wire stop_exec_i,
    input wire cpu_imask_i,
    // reset sources
    input wire por_i,
    input wire rst_pin_n_i,
    input wire watchdog_rst_i,
    input wire bad_instruction_i,
    input wire unmapped_access_i,
    input wire opcode_fetch_i,
    input wire undervoltage_i,
    input wire monitor_entry_i,
    // configuration bits
    input wire short_stop_recovery_i,
    input wire watchdog_disable_i,
    // outputs
    output reg internal_reset_o,
    output reg [4:0] vector_code_o,
    output reg irq_pending_o,
    output reg stack_start_o,
    output reg clear_imask_o,
    output reg cpu_clk_en_o,
    output reg periph_clk_en_o,
    output reg osc_clk_en_o,
    output reg watchdog_run_o,
    output reg flag_clear_allow_o,
    output reg in_break_o
);
    reg [`NUM_REQ-1:0] pend_ff;
    reg [7:0] cause_ff;
    reg exit_flag_ff;
    reg clear_en_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_low_ff;
    reg aw_ff, w_ff;
    reg [`ADDR_W-1:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [4:0] nxt_vec;
    reg timer_start, timer_hold;
    wire timer_done;
    wire any_reset;
    wire wake_irq;
    wire wr_fire;
    wire rd_fire;
    wire [17:0] wr_idx;
    wire [17:0] rd_idx;
    wire rd_cause;
    wire wr_exit_clr;

    // word index from a byte address; low two bits ignored
    function [17:0] word_idx;
        input [`ADDR_W-1:0] a;
        begin
            word_idx = a[`ADDR_W-1:2];
        end
    endfunction

    // pin reset passes three flops; changes count when stages two and three agree
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
            pin_s3_ff <= 1'b1;
            pin_low_ff <= 1'b0;
        end else begin
            pin_s1_ff <= rst_pin_n_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            if (pin_s2_ff == pin_s3_ff) begin
                pin_low_ff <= ~pin_s3_ff;
            end
        end
    end

    // all sources are ored: no priority among them
    assign any_reset = por_i | pin_low_ff | watchdog_rst_i | bad_instruction_i |
        (unmapped_access_i & opcode_fetch_i) | undervoltage_i | monitor_entry_i;
    assign wake_irq = |irq_req_i;

    // request lines copied into flags; bus writes never reach them
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_ff <= {`NUM_REQ{1'b0}};
        end else begin
            pend_ff <= irq_req_i;
        end
    end

    // priority encoder: break and software interrupt first, then lowest line
    integer k;
    always @* begin
        nxt_vec = `VEC_NONE;
        for (k = `NUM_REQ - 1; k >= 0; k = k - 1) begin
            if (irq_req_i[k] && !cpu_imask_i) begin
                nxt_vec = `VEC_BASE + k[4:0];
            end
        end
        if (swi_exec_i || break_i) begin
            nxt_vec = `VEC_SWI;
        end
    end

    // vector cleared to none while a reset is under way, since resets outrank interrupts
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vector_code_o <= `VEC_NONE;
            irq_pending_o <= 1'b0;
            internal_reset_o <= 1'b1;
            in_break_o <= 1'b0;
        end else begin
            internal_reset_o <= any_reset;
            in_break_o <= break_i;
            if (any_reset) begin
                vector_code_o <= `VEC_NONE;
                irq_pending_o <= 1'b0;
            end else begin
                vector_code_o <= nxt_vec;
                irq_pending_o <= (nxt_vec != `VEC_NONE);
            end
        end
    end

    // peripherals gate their own clears with this; two-step clears use it on step two
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_clear_allow_o <= 1'b1;
            watchdog_run_o <= 1'b0;
        end else begin
            flag_clear_allow_o <= ~break_i | clear_en_ff;
            watchdog_run_o <= ~watchdog_disable_i;
        end
    end

    // low power sequencer
    always @* begin
        nxt_state = state_ff;
        timer_start = 1'b0;
        timer_hold = 1'b0;
        case (state_ff)
            `ST_RUN: begin
                if (stop_exec_i) begin
                    nxt_state = `ST_STOP;
                end else if (wait_exec_i) begin
                    nxt_state = `ST_WAIT;
                end
            end
            `ST_WAIT: begin
                if (wake_irq || break_i) begin
                    nxt_state = `ST_RUN;
                end
            end
            `ST_STOP: begin
                timer_hold = 1'b1;
                if (wake_irq || break_i) begin
                    nxt_state = `ST_RECOVER;
                    timer_hold = 1'b0;
                    timer_start = 1'b1;
                end
            end
            `ST_RECOVER: begin
                if (timer_done) begin
                    nxt_state = `ST_RUN;
                end
            end
            default: begin
                nxt_state = `ST_RUN;
            end
        endcase
        if (any_reset) begin
            nxt_state = `ST_RUN;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= `ST_RUN;
            stack_start_o <= 1'b0;
            clear_imask_o <= 1'b0;
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_clk_en_o <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            clear_imask_o <= (state_ff == `ST_RUN) && (wait_exec_i || stop_exec_i)
                && !any_reset;
            // stacking one cycle after wake in wait, or after recovery in stop
            stack_start_o <= !any_reset && (((state_ff == `ST_WAIT) &&
                (wake_irq || break_i)) || ((state_ff == `ST_RECOVER) && timer_done));
            cpu_clk_en_o <= (nxt_state == `ST_RUN);
            periph_clk_en_o <= (nxt_state == `ST_RUN) || (nxt_state == `ST_WAIT);
            osc_clk_en_o <= (nxt_state != `ST_STOP);
        end
    end

    recovery_timer #(
        .LONG_CYCLES(LONG_CYCLES),
        .SHORT_CYCLES(SHORT_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .hold_clear_i(timer_hold),
        .start_i(timer_start),
        .short_i(short_stop_recovery_i),
        .done_o(timer_done)
    );

    // axi write channel: address and data taken in either order
    assign wr_fire = aw_ff && w_ff && !s_axi_bvalid;
    assign wr_idx = word_idx(awaddr_ff);
    assign wr_exit_clr = wr_fire && (wr_idx == `IDX_BREAK_STATUS) && wstrb_ff[0] &&
        !wdata_ff[`BWS_EXIT_BIT];

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= {`ADDR_W{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // pending registers accept writes silently
                case (wr_idx)
                    `IDX_BREAK_STATUS, `IDX_RESET_CAUSE, `IDX_BREAK_CTRL,
                    `IDX_PEND_A, `IDX_PEND_B, `IDX_PEND_C: s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_DECERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control bits; hardware set of the exit flag wins over a software clear
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clear_en_ff <= 1'b0;
            exit_flag_ff <= 1'b0;
        end else begin
            if (wr_fire && (wr_idx == `IDX_BREAK_CTRL) && wstrb_ff[0]) begin
                clear_en_ff <= wdata_ff[`BFC_ENABLE_BIT];
            end
            if ((state_ff == `ST_WAIT) && break_i) begin
                exit_flag_ff <= 1'b1;
            end else if (wr_exit_clr) begin
                exit_flag_ff <= 1'b0;
            end
        end
    end

    // axi read channel; one read in flight, answer the cycle after address
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = word_idx(s_axi_araddr);
    assign rd_cause = rd_fire && (rd_idx == `IDX_RESET_CAUSE);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                case (rd_idx)
                    `IDX_BREAK_STATUS: s_axi_rdata[7:0] <= {6'h00, exit_flag_ff, 1'b0};
                    `IDX_RESET_CAUSE: s_axi_rdata[7:0] <= cause_ff;
                    `IDX_BREAK_CTRL: s_axi_rdata[7:0] <= {clear_en_ff, 7'h00};
                    `IDX_PEND_A: s_axi_rdata[7:0] <= {pend_ff[5:0], 2'b00};
                    `IDX_PEND_B: s_axi_rdata[7:0] <= pend_ff[13:6];
                    `IDX_PEND_C: s_axi_rdata[7:0] <= {2'b00, pend_ff[19:14]};
                    default: s_axi_rresp <= `RESP_DECERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // reset cause flags: power-on overwrites, others accumulate, a read clears;
    // a source active in the read cycle still lands, so no cause is lost
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cause_ff <= `RC_RESET;
        end else begin
            if (por_i) begin
                cause_ff <= `RC_RESET;
            end else begin
                cause_ff <= (rd_cause ? `BYTE_ZERO : cause_ff) |
                    ({7'h00, pin_low_ff} << `RC_PIN) |
                    ({7'h00, watchdog_rst_i} << `RC_WDOG) |
                    ({7'h00, bad_instruction_i} << `RC_BADOP) |
                    ({7'h00, unmapped_access_i & opcode_fetch_i} << `RC_BADFETCH) |
                    ({7'h00, monitor_entry_i} << `RC_MONITOR) |
                    ({7'h00, undervoltage_i} << `RC_UNDERV);
            end
        end
    end
endmodule // system_integration_unit
